// file: hdl/supervisor_pkg.sv
package supervisor_pkg;

	localparam int unsigned      CNT_W            = 32;
	localparam int unsigned      CAP_W            = 16;
	localparam int unsigned      FRAC_BITS        = 16;

	// Clock period of the free-running timing oscillator
	localparam longint unsigned  CLK_PERIOD_NS    = 25;

	// Typical times, as printed, in ns
	localparam longint unsigned  RESET_DELAY_NS   = 25_000_000;
	localparam longint unsigned  WINDOW_SHORT_NS  = 250_000_000;
	localparam longint unsigned  WINDOW_LONG_NS   = 2_500_000_000;
	localparam longint unsigned  BOUND_SS_LO_NS   = 7_860_000;
	localparam longint unsigned  BOUND_SS_HI_NS   = 2_000_000;
	localparam longint unsigned  BOUND_LS_LO_NS   = 78_200_000;
	localparam longint unsigned  BOUND_LS_HI_NS   = 19_600_000;
	localparam longint unsigned  CAP_STEP_NS      = 6_250_000;

	// Capacitor unit 15.55 pF in hundredths of a pF
	localparam longint unsigned  CAP_UNIT_CPF     = 1555;

	// Divisors 25.8 and 64.5 held in tenths
	localparam longint unsigned  RATIO_LO_X10     = 258;
	localparam longint unsigned  RATIO_HI_X10     = 645;

	// Cycle counts derived from the times
	localparam int unsigned RESET_DELAY_CYC = int'(RESET_DELAY_NS / CLK_PERIOD_NS);
	localparam int unsigned WINDOW_SHORT_CYC = int'(WINDOW_SHORT_NS / CLK_PERIOD_NS);
	localparam int unsigned WINDOW_LONG_CYC = int'(WINDOW_LONG_NS / CLK_PERIOD_NS);
	localparam int unsigned BOUND_SS_LO_CYC = int'(BOUND_SS_LO_NS / CLK_PERIOD_NS);
	localparam int unsigned BOUND_SS_HI_CYC = int'(BOUND_SS_HI_NS / CLK_PERIOD_NS);
	localparam int unsigned BOUND_LS_LO_CYC = int'(BOUND_LS_LO_NS / CLK_PERIOD_NS);
	localparam int unsigned BOUND_LS_HI_CYC = int'(BOUND_LS_HI_NS / CLK_PERIOD_NS);
	localparam int unsigned CAP_STEP_CYC = int'(CAP_STEP_NS / CLK_PERIOD_NS);
	localparam int unsigned CAP_PER_PF_CYC = int'(CAP_STEP_NS * 100 / (CLK_PERIOD_NS * CAP_UNIT_CPF));
	localparam int unsigned RATIO_LO_FRAC = int'((longint'(1) << FRAC_BITS) * 10 / RATIO_LO_X10);
	localparam int unsigned RATIO_HI_FRAC = int'((longint'(1) << FRAC_BITS) * 10 / RATIO_HI_X10);

	typedef logic [CNT_W-1:0] cnt_type;

	// Gray order along hold -> delay -> first window -> running window
	typedef enum logic [1:0] {
		ST_HOLD  = 2'b00,
		ST_DELAY = 2'b01,
		ST_FIRST = 2'b11,
		ST_RUN   = 2'b10
	} sup_state_type;

	// Multiply by a 16-bit fixed-point fraction
	function automatic cnt_type scale_frac(input cnt_type value, input int unsigned frac);
		logic [CNT_W+FRAC_BITS-1:0] prod;
		prod = {{FRAC_BITS{1'b0}}, value} * (CNT_W+FRAC_BITS)'(frac);
		return prod[CNT_W+FRAC_BITS-1:FRAC_BITS];
	endfunction

endpackage

// file: hdl/trigger_edge.sv
`timescale 1ns/100ps
module trigger_edge
	import supervisor_pkg::*;
(
	input  wire logic clk,        // Oscillator clock
	input  wire logic rst_n,      // Async reset, active low
	input  wire logic clk_en,     // Freezes state while low
	input  wire logic trig_in,    // Trigger from the processor
	output logic      rise_q      // One-cycle pulse per rising edge
);

	logic prev_q;
	logic prev_d;
	logic rise_d;

	always_comb
	begin
		prev_d = trig_in;
		rise_d = trig_in & ~prev_q;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prev_q <= 1'b0;
			rise_q <= 1'b0;
		end
		else if (clk_en)
		begin
			prev_q <= prev_d;
			rise_q <= rise_d;
		end
	end

	rise_once_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && rise_q |-> !trig_in || prev_q)
		else $error("edge pulse without a rising edge");

endmodule // trigger_edge

// file: hdl/window_limits.sv
`timescale 1ns/100ps
module window_limits
	import supervisor_pkg::*;
#(
	parameter int unsigned WIN_SHORT = WINDOW_SHORT_CYC,
	parameter int unsigned WIN_LONG  = WINDOW_LONG_CYC,
	parameter int unsigned B_SS_LO   = BOUND_SS_LO_CYC,
	parameter int unsigned B_SS_HI   = BOUND_SS_HI_CYC,
	parameter int unsigned B_LS_LO   = BOUND_LS_LO_CYC,
	parameter int unsigned B_LS_HI   = BOUND_LS_HI_CYC
)(
	input  wire logic             clk,            // Oscillator clock
	input  wire logic             rst_n,          // Async reset, active low
	input  wire logic             clk_en,         // Freezes state while low
	input  wire logic             capture,        // Follow straps while high
	input  wire logic             timeout_select, // Strap: long window
	input  wire logic             cap_mode,       // Strap: capacitor fitted
	input  wire logic [CAP_W-1:0] cap_pf,         // Capacitance in pF
	input  wire logic             ratio_select,   // Strap: narrow boundary
	output cnt_type               window_q,       // Window length, cycles
	output cnt_type               boundary_q      // Lower boundary, cycles
);

	cnt_type window_d;
	cnt_type boundary_d;
	cnt_type cap_window;

	always_comb
	begin
		// Typical capacitor window; spread of 0.75..1.25 is analog tolerance
		cap_window = CNT_W'(CAP_STEP_CYC) + CNT_W'(cap_pf) * CNT_W'(CAP_PER_PF_CYC);
		window_d   = window_q;
		boundary_d = boundary_q;
		if (capture)
		begin
			if (cap_mode)
			begin
				window_d   = cap_window;
				boundary_d = scale_frac(cap_window, ratio_select ? RATIO_HI_FRAC
					: RATIO_LO_FRAC);
			end
			else if (timeout_select)
			begin
				window_d   = CNT_W'(WIN_LONG);
				boundary_d = CNT_W'(ratio_select ? B_LS_HI : B_LS_LO);
			end
			else
			begin
				window_d   = CNT_W'(WIN_SHORT);
				boundary_d = CNT_W'(ratio_select ? B_SS_HI : B_SS_LO);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			window_q   <= CNT_W'(WINDOW_SHORT_CYC);
			boundary_q <= CNT_W'(BOUND_SS_LO_CYC);
		end
		else if (clk_en)
		begin
			window_q   <= window_d;
			boundary_q <= boundary_d;
		end
	end

	straps_frozen_a: assert property (@(posedge clk) disable iff (!rst_n)
		!capture |=> $stable(window_q) && $stable(boundary_q))
		else $error("limits changed outside reset");

	long_window_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && capture && !cap_mode && timeout_select |=> window_q == CNT_W'(WIN_LONG))
		else $error("long window not selected");

	cap_boundary_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && capture && cap_mode |=> boundary_q < window_q)
		else $error("capacitor boundary not below window");

endmodule // window_limits

// file: hdl/window_watchdog_supervisor.sv
`timescale 1ns/100ps
module window_watchdog_supervisor
	import supervisor_pkg::*;
#(
	parameter int unsigned RESET_DELAY = RESET_DELAY_CYC,
	parameter int unsigned WIN_SHORT   = WINDOW_SHORT_CYC,
	parameter int unsigned WIN_LONG    = WINDOW_LONG_CYC,
	parameter int unsigned B_SS_LO     = BOUND_SS_LO_CYC,
	parameter int unsigned B_SS_HI     = BOUND_SS_HI_CYC,
	parameter int unsigned B_LS_LO     = BOUND_LS_LO_CYC,
	parameter int unsigned B_LS_HI     = BOUND_LS_HI_CYC
)(
	input  wire logic             clk,                 // Free-running oscillator
	input  wire logic             rst_n,               // Async reset, active low
	input  wire logic             clk_en,              // Freezes state while low
	input  wire logic             supply_good,         // Supply above supply_threshold
	input  wire logic             watchdog_trigger_in, // Trigger from processor
	input  wire logic             timeout_select,      // Strap: long window
	input  wire logic             timeout_cap_mode,    // Strap: capacitor fitted
	input  wire logic [CAP_W-1:0] timeout_cap_pf,      // Capacitance in pF
	input  wire logic             ratio_select,        // Strap: narrow boundary
	output logic                  reset_out_n,         // Reset level, low asserted
	output logic                  reset_oe_n,          // Open-drain enable, low drives
	output logic                  early_trigger_pulse, // Trigger inside boundary of a running window
	output logic                  timeout_pulse        // Window expired
);

	////////////////////////////////////////////////////////////////////////////
	// Trigger edge and window limits

	logic    trig_rise;
	cnt_type window_cyc;
	cnt_type boundary_cyc;

	trigger_edge u_edge (
		.clk     (clk),
		.rst_n   (rst_n),
		.clk_en  (clk_en),
		.trig_in (watchdog_trigger_in),
		.rise_q  (trig_rise)
	);

	// Straps follow only while reset is driven, so a live change cannot
	// move the window under a running program
	window_limits #(
		.WIN_SHORT (WIN_SHORT),
		.WIN_LONG  (WIN_LONG),
		.B_SS_LO   (B_SS_LO),
		.B_SS_HI   (B_SS_HI),
		.B_LS_LO   (B_LS_LO),
		.B_LS_HI   (B_LS_HI)
	) u_limits (
		.clk            (clk),
		.rst_n          (rst_n),
		.clk_en         (clk_en),
		.capture        (!reset_out_n),
		.timeout_select (timeout_select),
		.cap_mode       (timeout_cap_mode),
		.cap_pf         (timeout_cap_pf),
		.ratio_select   (ratio_select),
		.window_q       (window_cyc),
		.boundary_q     (boundary_cyc)
	);

	////////////////////////////////////////////////////////////////////////////
	// Supervisor state and shared timer

	sup_state_type state_q;
	sup_state_type state_d;
	cnt_type       cnt_q;
	cnt_type       cnt_d;
	logic          early_d;
	logic          tmo_d;
	logic          rst_rel_d;

	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q + 1'b1;
		early_d = 1'b0;
		tmo_d   = 1'b0;
		if (!supply_good)
		begin
			state_d = ST_HOLD;
			cnt_d   = '0;
		end
		else
		begin
			unique case (state_q)
				ST_HOLD:
				begin
					state_d = ST_DELAY;
					cnt_d   = '0;
				end
				ST_DELAY:
				begin
					if (cnt_q >= CNT_W'(RESET_DELAY) - 1'b1)
					begin
						state_d = ST_FIRST;
						cnt_d   = '0;
					end
				end
				ST_FIRST, ST_RUN:
				begin
					if (trig_rise)
					begin
						cnt_d = '0;
						if (state_q == ST_RUN && cnt_q < boundary_cyc)
						begin
							early_d = 1'b1;
							state_d = ST_DELAY;
						end
						else
						begin
							state_d = ST_RUN;
						end
					end
					else if (cnt_q >= window_cyc - 1'b1)
					begin
						tmo_d   = 1'b1;
						state_d = ST_DELAY;
						cnt_d   = '0;
					end
				end
			endcase
		end
		rst_rel_d = (state_d == ST_FIRST) || (state_d == ST_RUN);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q             <= ST_HOLD;
			cnt_q               <= '0;
			reset_out_n         <= 1'b0;
			reset_oe_n          <= 1'b0;
			early_trigger_pulse <= 1'b0;
			timeout_pulse       <= 1'b0;
		end
		else if (clk_en)
		begin
			state_q             <= state_d;
			cnt_q               <= cnt_d;
			reset_out_n         <= rst_rel_d;
			reset_oe_n          <= rst_rel_d;
			early_trigger_pulse <= early_d;
			timeout_pulse       <= tmo_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	hold_asserted_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_q == ST_HOLD |-> !reset_out_n && !reset_oe_n)
		else $error("reset released while supply low");

	supply_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && !supply_good |=> !reset_out_n ##0 state_q == ST_HOLD)
		else $error("supply drop did not assert reset");

	release_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(reset_out_n) |-> $past(state_q) == ST_DELAY
			&& $past(cnt_q) == CNT_W'(RESET_DELAY) - 1'b1)
		else $error("reset released before delay end");

	good_release_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && supply_good && state_q == ST_DELAY
			&& cnt_q == CNT_W'(RESET_DELAY) - 1'b1 |=> reset_out_n)
		else $error("reset not released after delay");

	timer_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && supply_good && state_q == ST_RUN && trig_rise
			&& cnt_q >= boundary_cyc |=> cnt_q == '0 && reset_out_n)
		else $error("trigger did not restart the window");

	first_window_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && supply_good && state_q == ST_FIRST && trig_rise
			|=> state_q == ST_RUN && reset_out_n && !early_trigger_pulse)
		else $error("first window trigger rejected");

	early_trigger_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && supply_good && state_q == ST_RUN && trig_rise && cnt_q < boundary_cyc
			|=> early_trigger_pulse && !reset_out_n && state_q == ST_DELAY)
		else $error("early trigger not punished");

	timeout_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && supply_good && (state_q == ST_FIRST || state_q == ST_RUN) && !trig_rise
			&& cnt_q >= window_cyc - 1'b1 |=> timeout_pulse && !reset_out_n)
		else $error("window expiry not punished");

	violation_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
		early_trigger_pulse || timeout_pulse |-> state_q == ST_DELAY && cnt_q == '0)
		else $error("violation skipped the release delay");

	////////////////////////////////////////////////////////////////////////////
	// Output shape and counter range

	// The pin enable must never disagree with the level, or the pin floats
	oe_follows_a: assert property (@(posedge clk) disable iff (!rst_n)
		reset_oe_n == reset_out_n)
		else $error("drive enable differs from reset level");

	pulse_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
		!(early_trigger_pulse && timeout_pulse))
		else $error("both violation pulses at once");

	early_once_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && early_trigger_pulse |=> !early_trigger_pulse)
		else $error("early pulse longer than one cycle");

	tmo_once_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && timeout_pulse |=> !timeout_pulse)
		else $error("timeout pulse longer than one cycle");

	delay_holds_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_q == ST_DELAY |-> !reset_out_n)
		else $error("reset released during delay");

	run_released_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_q == ST_FIRST || state_q == ST_RUN |-> reset_out_n)
		else $error("reset held while watching");

	delay_count_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_q == ST_DELAY |-> cnt_q < CNT_W'(RESET_DELAY))
		else $error("delay counter overran");

	// Counter can reach window-1 at most; a trigger there is still in time
	window_count_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_q == ST_FIRST || state_q == ST_RUN |-> cnt_q < window_cyc)
		else $error("window counter overran");

	hold_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && !supply_good |=> cnt_q == '0)
		else $error("supply drop left timer running");

	hold_leave_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && supply_good && state_q == ST_HOLD
			|=> state_q == ST_DELAY && cnt_q == '0)
		else $error("delay did not start from zero");

	first_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && supply_good && state_q == ST_DELAY
			&& cnt_q == CNT_W'(RESET_DELAY) - 1'b1 |=> state_q == ST_FIRST && cnt_q == '0)
		else $error("release did not open a first window");

	freeze_a: assert property (@(posedge clk) disable iff (!rst_n)
		!clk_en |=> $stable(state_q) && $stable(cnt_q) && $stable(reset_out_n))
		else $error("state moved while clock enable low");

	count_step_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && supply_good && state_q == ST_RUN && !trig_rise
			&& cnt_q < window_cyc - 1'b1 |=> cnt_q == $past(cnt_q) + 1'b1)
		else $error("window counter skipped a cycle");

	accepted_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && supply_good && state_q == ST_RUN && trig_rise
			&& cnt_q >= boundary_cyc |=> !early_trigger_pulse && !timeout_pulse)
		else $error("good trigger flagged as violation");

	hold_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_q == ST_HOLD |-> !early_trigger_pulse && !timeout_pulse)
		else $error("violation pulse while supply low");

	// A boundary at or above the window would make every running-window trigger early
	boundary_below_a: assert property (@(posedge clk) disable iff (!rst_n)
		boundary_cyc < window_cyc)
		else $error("lower boundary not below window");

	release_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(reset_out_n));
	accept_c:  cover property (@(posedge clk) disable iff (!rst_n)
		state_q == ST_RUN && trig_rise && cnt_q >= boundary_cyc);
	early_c:   cover property (@(posedge clk) disable iff (!rst_n) early_trigger_pulse);
	timeout_c: cover property (@(posedge clk) disable iff (!rst_n) timeout_pulse);
	first_c:   cover property (@(posedge clk) disable iff (!rst_n)
		state_q == ST_FIRST && trig_rise);

endmodule // window_watchdog_supervisor

// file: test/trigger_source.sv
`timescale 1ns/100ps
module trigger_source
(
	input  wire logic clk,  // Oscillator clock
	input  wire logic arm,  // Request one trigger edge
	input  int        gap,  // Cycles since previous rise
	output logic      trig  // Trigger toward the supervisor
);
	int since;

	initial
	begin
		trig = 1'b0;
		since = 1000;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Holds each pulse two cycles so the oscillator always samples it
	// Gap is set by the bench, so it can trigger well or badly on purpose
	always @(negedge clk)
	begin
		since <= since + 1;
		if (trig && since >= 1)
			trig <= 1'b0;
		else if (arm && !trig && since >= gap)
		begin
			trig <= 1'b1;
			since <= 0;
		end
	end
endmodule // trigger_source

// file: test/window_watchdog_supervisor_bench.sv
`timescale 1ns/100ps
module window_watchdog_supervisor_bench;
	import supervisor_pkg::*;
	localparam int RD = 20;
	localparam int WS = 200;
	localparam int WL = 400;
	// Boundaries indexed by {timeout_select, ratio_select}
	localparam int BND [4] = '{40, 10, 80, 20};
	logic             clk, rst_n, clk_en, supply_good, trig, ts, cap, rs, arm;
	logic [CAP_W-1:0] cap_pf;
	logic             reset_out_n, reset_oe_n, early, tmo, early_seen, tmo_seen;
	logic [31:0]      lfsr_q;
	int               gap, fail_count, checks_done, bnd, win, first_win;

	window_watchdog_supervisor #(.RESET_DELAY(RD), .WIN_SHORT(WS), .WIN_LONG(WL),
		.B_SS_LO(BND[0]), .B_SS_HI(BND[1]), .B_LS_LO(BND[2]), .B_LS_HI(BND[3])) dut_u (
		.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .supply_good(supply_good),
		.watchdog_trigger_in(trig), .timeout_select(ts), .timeout_cap_mode(cap),
		.timeout_cap_pf(cap_pf), .ratio_select(rs), .reset_out_n(reset_out_n),
		.reset_oe_n(reset_oe_n), .early_trigger_pulse(early), .timeout_pulse(tmo));

	trigger_source proc_u (.clk(clk), .arm(arm), .gap(gap), .trig(trig));

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// One-cycle pulses are latched so the bench can look after settling
	always @(posedge clk)
	begin
		if (early === 1'b1) early_seen <= 1'b1;
		if (tmo === 1'b1) tmo_seen <= 1'b1;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic wait_release(input int lo, input int hi);
		int n;
		n = 0;
		while (reset_out_n !== 1'b1 && n < 2000)
		begin
			@(negedge clk);
			n++;
		end
		check("release delay", n >= lo && n <= hi, 1);
		check("drive enable", reset_oe_n, reset_out_n);
	endtask

	// The model decides early or accepted from the gap and the first-window flag
	task automatic fire(input int g);
		logic exp;
		int   k;
		exp = (first_win == 0) && (g < bnd);
		early_seen = 1'b0;
		gap <= g;
		arm <= 1'b1;
		k = 0;
		while (trig !== 1'b1 && k < 30000)
		begin
			@(negedge clk);
			k++;
		end
		arm <= 1'b0;
		repeat (2) @(negedge clk);
		check("early pulse", early_seen, exp);
		check("reset level", reset_out_n, !exp);
		first_win = exp;
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#2_000_000;
		fail_count++;
		test_done();
	end

	initial
	begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		supply_good = 1'b0;
		{ts, cap, rs, arm} = 4'h0;
		cap_pf = '0;
		gap = 0;
		lfsr_q = 32'hcb30;
		repeat (2) @(negedge clk);
		check("reset at power-up", reset_out_n, 0);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		check("reset supply low", reset_out_n, 0);
		for (int i = 0; i < 4; i++)
		begin
			// Straps change only while reset is asserted
			{ts, rs} = i[1:0];
			bnd = BND[i];
			win = ts ? WL : WS;
			supply_good = 1'b1;
			wait_release(RD + 1, RD + 1);
			first_win = 1;
			fire(3);
			lfsr_q = lfsr_next(lfsr_q);
			fire(bnd + 3 + int'(lfsr_q % (win - bnd - 12)));
			fire(bnd - 3);
			wait_release(RD - 1, RD);
			fire(3);
			tmo_seen = 1'b0;
			repeat (win - 8) @(negedge clk);
			check("early timeout", tmo_seen, 0);
			for (int k = 0; k < 12 && tmo_seen !== 1'b1; k++)
				@(negedge clk);
			check("timeout pulse", tmo_seen, 1);
			wait_release(RD - 1, RD + 1);
			supply_good = 1'b0;
			@(negedge clk);
			check("supply drop", reset_out_n, 0);
		end
		// Capacitor mode at zero pF: one 6.25 ms step, boundary window over 25.8
		cap = 1'b1;
		rs = 1'b0;
		bnd = 250000 * 10 / 258;
		supply_good = 1'b1;
		wait_release(RD + 1, RD + 1);
		first_win = 1;
		fire(3);
		fire(bnd + 300);
		fire(bnd - 300);
		wait_release(RD - 1, RD);
		test_done();
	end
endmodule // window_watchdog_supervisor_bench
